// ==== core/smc_map.vh ====
/*
 * Register addresses, field positions, reset values and timing counts for the
 * system control block (safe-mode unlock, global config, flash control).
 * Assumes an 8-bit special function register port and a 40 MHz clock.
 */
`ifndef SMC_MAP_VH
`define SMC_MAP_VH

// special function register addresses
`define SMC_ADDR_FLASH_ADDR_LO 8'h84
`define SMC_ADDR_FLASH_ADDR_HI 8'h85
`define SMC_ADDR_FLASH_STAT 8'h86
`define SMC_ADDR_FLASH_WORD_LO 8'h8e
`define SMC_ADDR_FLASH_WORD_HI 8'h8f
`define SMC_ADDR_GLOBAL_CFG 8'hb1
`define SMC_ADDR_UNLOCK 8'ha1

// unlock sequence and safe window (system clock periods)
`define SMC_UNLOCK_KEY1 8'h55
`define SMC_UNLOCK_KEY2 8'haa
`define SMC_SAFE_MIN_CYC 5'd13
`define SMC_SAFE_MAX_CYC 5'd23
`define SMC_SAFE_CYC 5'd16

// global configuration fields
`define SMC_CFG_BOOT_BIT 5
`define SMC_CFG_SWRST_BIT 4
`define SMC_CFG_CODE_WE_BIT 3
`define SMC_CFG_DATA_WE_BIT 2
`define SMC_CFG_XREG_ONLY_BIT 1
`define SMC_CFG_WDOG_BIT 0
`define SMC_CFG_FIXED_HI 2'b11

// flash commands and status
`define SMC_CMD_ERASE 8'ha6
`define SMC_CMD_PROGRAM 8'h9a
`define SMC_STAT_RESET 8'h80
`define SMC_STAT_ADDR_OK_BIT 6
`define SMC_STAT_CMD_ERR_BIT 1
`define SMC_STAT_TOUT_BIT 0

// flash regions and data address decode
`define SMC_DFLASH_LO 16'hf000
`define SMC_DFLASH_HI 16'hf3ff
`define SMC_BOOT_START 16'hf400
`define SMC_APP_START 16'h0000
`define SMC_XREG_LO 16'h2440
`define SMC_XREG_HI 16'h298f
`define SMC_XRAM_HI 16'h17ff
`define SMC_XBUS_LO 16'h4000

// configuration word fields
`define SMC_CW_PROTECT_BIT 15
`define SMC_CW_BOOT_BIT 14
`define SMC_CW_LONGRST_BIT 13
`define SMC_CW_EXTRST_BIT 11
`define SMC_CW_PULLUP_BIT 10

// long power-up reset: 87 ms at 40 MHz
`define SMC_LONG_RESET_MS 87
`define SMC_CLK_KHZ 40000
`define SMC_LONG_RESET_CYC (`SMC_LONG_RESET_MS * `SMC_CLK_KHZ)

// flash operation: busy cycles and timeout guard
`define SMC_FLASH_BUSY_CYC 8'd64

`endif

// ==== core/smc_sysctl.v ====
/*
 * System control block: safe-mode unlock, global configuration, part_identification,
 * flash address/data/command/status registers, boot and reset helpers and
 * the external data space decode.
 * Assumes a single-cycle SFR port (address, write strobe, read data) from the
 * CPU, and a flash macro that acknowledges each erase or program with done.
 */
`timescale 1ns/1ps
`default_nettype none
`include "smc_map.vh"


module smc_sysctl #(
    parameter [7:0] PART_ID = 8'h3c, // arbitrary id value, no real part code
    parameter [31:0] LONG_RESET_CYC = `SMC_LONG_RESET_CYC
) (
    input wire ref_clk_i,
    input wire srst_i,
    input wire por_i,
    input wire [7:0] sfr_addr_i,
    input wire sfr_wr_i,
    input wire [7:0] sfr_wdata_i,
    output reg [7:0] sfr_rdata_o,
    input wire [15:0] config_word_i,
    input wire watchdog_overflow_i,
    input wire [15:0] xdata_addr_i,
    input wire xdata_indirect_i,
    output wire xdata_ram_sel_o,
    output wire xdata_xreg_sel_o,
    output wire xdata_xbus_sel_o,
    input wire flash_done_i,
    output reg flash_erase_o,
    output reg flash_program_o,
    output wire [15:0] flash_addr_o,
    output wire [15:0] flash_wdata_o,
    output wire cpu_stall_o,
    output wire soft_reset_o,
    output wire watchdog_reset_o,
    output wire [15:0] boot_start_o,
    output wire ext_read_allow_o,
    output wire external_reset_pin_enable_o,
    output wire port0_reset_pullup_enable_o,
    output wire reset_hold_o,
    output wire code_area_write_enable_o,
    output wire data_area_write_enable_o
);
    localparam ST_IDLE = 2'd0;
    localparam ST_KEY1 = 2'd1;
    localparam ST_SAFE = 2'd2;
    localparam FL_IDLE = 1'b0;
    localparam FL_BUSY = 1'b1;

    // decode of one SFR write address, reused for each register
    function wr_hit;
        input [7:0] addr;
        input [7:0] target;
        input wr;
        begin
            wr_hit = wr && (addr == target);
        end
    endfunction

    reg [1:0] unlock_state;
    reg [4:0] safe_cnt;
    reg boot_origin_flag;
    reg soft_reset_trigger;
    reg code_area_write_enable;
    reg data_area_write_enable;
    reg indirect_extreg_only_select;
    reg watchdog_reset_enable;
    reg [7:0] flash_addr_lo;
    reg [7:0] flash_addr_hi;
    reg [7:0] flash_word_lo;
    reg [7:0] flash_word_hi;
    reg [7:0] flash_status;
    reg fl_state;
    reg [7:0] fl_cnt;
    reg [31:0] hold_cnt;
    reg hold_armed;
    wire safe_open;
    wire wr_unlock;
    wire wr_cfg;
    wire wr_cmd;
    wire [15:0] cmd_addr;
    wire in_dflash;
    wire region_we;
    wire addr_ok;

    assign safe_open = (unlock_state == ST_SAFE);
    assign wr_unlock = wr_hit(sfr_addr_i, `SMC_ADDR_UNLOCK, sfr_wr_i);
    assign wr_cfg = wr_hit(sfr_addr_i, `SMC_ADDR_GLOBAL_CFG, sfr_wr_i);
    assign wr_cmd = wr_hit(sfr_addr_i, `SMC_ADDR_FLASH_STAT, sfr_wr_i);
    assign cmd_addr = {flash_addr_hi, flash_addr_lo};
    assign in_dflash = (cmd_addr >= `SMC_DFLASH_LO) && (cmd_addr <= `SMC_DFLASH_HI);
    assign region_we = in_dflash ? data_area_write_enable : code_area_write_enable;
    assign addr_ok = 1'b1;

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            unlock_state <= ST_IDLE;
            safe_cnt <= 5'd0;
        end
        else
        begin
            case (unlock_state)
                ST_IDLE:
                begin
                    if (wr_unlock && sfr_wdata_i == `SMC_UNLOCK_KEY1)
                        unlock_state <= ST_KEY1;
                end
                ST_KEY1:
                begin
                    if (wr_unlock)
                    begin
                        if (sfr_wdata_i == `SMC_UNLOCK_KEY2)
                        begin
                            unlock_state <= ST_SAFE;
                            safe_cnt <= `SMC_SAFE_CYC;
                        end
                        else if (sfr_wdata_i != `SMC_UNLOCK_KEY1)
                            unlock_state <= ST_IDLE;
                    end
                    else if (sfr_wr_i)
                        unlock_state <= ST_IDLE;
                end
                ST_SAFE:
                begin
                    if (wr_unlock)
                        unlock_state <= ST_IDLE;
                    else if (safe_cnt == 5'd1)
                        unlock_state <= ST_IDLE;
                    safe_cnt <= safe_cnt - 5'd1;
                end
                default:
                    unlock_state <= ST_IDLE;
            endcase
        end
    end

    // power-on flag ignores srst_i: por sets it and a soft reset trigger clears it
    always @(posedge ref_clk_i)
    begin
        if (por_i)
            boot_origin_flag <= 1'b1;
        else if (soft_reset_trigger)
            boot_origin_flag <= 1'b0;
    end

    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            soft_reset_trigger <= 1'b0;
            code_area_write_enable <= 1'b0;
            data_area_write_enable <= 1'b0;
            indirect_extreg_only_select <= 1'b0;
            watchdog_reset_enable <= 1'b0;
        end
        else if (wr_cfg && safe_open)
        begin
            soft_reset_trigger <= sfr_wdata_i[`SMC_CFG_SWRST_BIT];
            code_area_write_enable <= sfr_wdata_i[`SMC_CFG_CODE_WE_BIT];
            data_area_write_enable <= sfr_wdata_i[`SMC_CFG_DATA_WE_BIT];
            indirect_extreg_only_select <= sfr_wdata_i[`SMC_CFG_XREG_ONLY_BIT];
            watchdog_reset_enable <= sfr_wdata_i[`SMC_CFG_WDOG_BIT];
        end
        else
            soft_reset_trigger <= 1'b0;
    end

    assign soft_reset_o = soft_reset_trigger;
    assign watchdog_reset_o = watchdog_reset_enable & watchdog_overflow_i;
    assign code_area_write_enable_o = code_area_write_enable;
    assign data_area_write_enable_o = data_area_write_enable;

    // address and data hold until rewritten
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            flash_addr_lo <= 8'h00;
            flash_addr_hi <= 8'h00;
            flash_word_lo <= 8'h00;
            flash_word_hi <= 8'h00;
        end
        else
        begin
            if (wr_hit(sfr_addr_i, `SMC_ADDR_FLASH_ADDR_LO, sfr_wr_i))
                flash_addr_lo <= {sfr_wdata_i[7:1], 1'b0};
            if (wr_hit(sfr_addr_i, `SMC_ADDR_FLASH_ADDR_HI, sfr_wr_i))
                flash_addr_hi <= sfr_wdata_i;
            if (wr_hit(sfr_addr_i, `SMC_ADDR_FLASH_WORD_LO, sfr_wr_i))
                flash_word_lo <= sfr_wdata_i;
            if (wr_hit(sfr_addr_i, `SMC_ADDR_FLASH_WORD_HI, sfr_wr_i))
                flash_word_hi <= sfr_wdata_i;
        end
    end

    // erase takes the 1K block base, program the even word
    assign flash_addr_o = flash_erase_o ? {cmd_addr[15:10], 10'h000} : cmd_addr;
    assign flash_wdata_o = {flash_word_hi, flash_word_lo};

    // flash command engine; timeout guards a macro that never answers
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
        begin
            fl_state <= FL_IDLE;
            fl_cnt <= 8'h00;
            flash_erase_o <= 1'b0;
            flash_program_o <= 1'b0;
            flash_status <= `SMC_STAT_RESET;
        end
        else
        begin
            case (fl_state)
                FL_IDLE:
                begin
                    if (wr_cmd)
                    begin
                        flash_status <= `SMC_STAT_RESET;
                        if (sfr_wdata_i == `SMC_CMD_ERASE || sfr_wdata_i == `SMC_CMD_PROGRAM)
                        begin
                            flash_status[`SMC_STAT_ADDR_OK_BIT] <= addr_ok & region_we;
                            if (region_we)
                            begin
                                fl_state <= FL_BUSY;
                                fl_cnt <= `SMC_FLASH_BUSY_CYC;
                                flash_erase_o <= (sfr_wdata_i == `SMC_CMD_ERASE);
                                flash_program_o <= (sfr_wdata_i == `SMC_CMD_PROGRAM);
                            end
                        end
                        else
                            flash_status[`SMC_STAT_CMD_ERR_BIT] <= 1'b1;
                    end
                end
                FL_BUSY:
                begin
                    fl_cnt <= fl_cnt - 8'h01;
                    if (flash_done_i || fl_cnt == 8'h01)
                    begin
                        fl_state <= FL_IDLE;
                        flash_erase_o <= 1'b0;
                        flash_program_o <= 1'b0;
                        flash_status[`SMC_STAT_TOUT_BIT] <= ~flash_done_i;
                    end
                end
                default:
                    fl_state <= FL_IDLE;
            endcase
        end
    end

    assign cpu_stall_o = (fl_state == FL_BUSY);

    always @(posedge ref_clk_i)
    begin
        if (por_i)
        begin
            hold_cnt <= 32'd0;
            hold_armed <= 1'b1;
        end
        else if (hold_armed)
        begin
            if (!config_word_i[`SMC_CW_LONGRST_BIT] || hold_cnt >= LONG_RESET_CYC - 32'd1)
                hold_armed <= 1'b0;
            else
                hold_cnt <= hold_cnt + 32'd1;
        end
    end
    assign reset_hold_o = hold_armed & config_word_i[`SMC_CW_LONGRST_BIT];

    assign ext_read_allow_o = config_word_i[`SMC_CW_PROTECT_BIT];
    assign boot_start_o = config_word_i[`SMC_CW_BOOT_BIT] ? `SMC_BOOT_START : `SMC_APP_START;
    assign external_reset_pin_enable_o = config_word_i[`SMC_CW_EXTRST_BIT];
    assign port0_reset_pullup_enable_o = config_word_i[`SMC_CW_PULLUP_BIT] & (srst_i | reset_hold_o);

    wire in_xreg = (xdata_addr_i >= `SMC_XREG_LO) && (xdata_addr_i <= `SMC_XREG_HI);
    wire xreg_only = xdata_indirect_i & indirect_extreg_only_select;
    assign xdata_xreg_sel_o = in_xreg | xreg_only;
    assign xdata_ram_sel_o = !xreg_only && (xdata_addr_i <= `SMC_XRAM_HI);
    assign xdata_xbus_sel_o = !xreg_only && (xdata_addr_i >= `SMC_XBUS_LO);

    // read mux; unlock address reads back the part id
    always @(posedge ref_clk_i)
    begin
        if (srst_i)
            sfr_rdata_o <= 8'h00;
        else
        begin
            case (sfr_addr_i)
                `SMC_ADDR_FLASH_ADDR_LO: sfr_rdata_o <= flash_addr_lo;
                `SMC_ADDR_FLASH_ADDR_HI: sfr_rdata_o <= flash_addr_hi;
                `SMC_ADDR_FLASH_STAT: sfr_rdata_o <= flash_status;
                `SMC_ADDR_FLASH_WORD_LO: sfr_rdata_o <= flash_word_lo;
                `SMC_ADDR_FLASH_WORD_HI: sfr_rdata_o <= flash_word_hi;
                `SMC_ADDR_GLOBAL_CFG: sfr_rdata_o <= {`SMC_CFG_FIXED_HI, boot_origin_flag,
                    soft_reset_trigger, code_area_write_enable, data_area_write_enable,
                    indirect_extreg_only_select, watchdog_reset_enable};
                `SMC_ADDR_UNLOCK: sfr_rdata_o <= PART_ID;
                default: sfr_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== bench/smc_sysctl_checker.sv ====
/*
 * Concurrent checks on the system control block's ports.
 * Assumes one clock domain and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none
module smc_sysctl_checker (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [15:0] config_word_i,
    input wire logic watchdog_overflow_i,
    input wire logic [15:0] xdata_addr_i,
    input wire logic xdata_indirect_i,
    input wire logic xdata_ram_sel_o,
    input wire logic xdata_xreg_sel_o,
    input wire logic xdata_xbus_sel_o,
    input wire logic flash_done_i,
    input wire logic flash_erase_o,
    input wire logic flash_program_o,
    input wire logic [15:0] flash_addr_o,
    input wire logic cpu_stall_o,
    input wire logic soft_reset_o,
    input wire logic watchdog_reset_o,
    input wire logic [15:0] boot_start_o,
    input wire logic ext_read_allow_o,
    input wire logic external_reset_pin_enable_o,
    input wire logic code_area_write_enable_o,
    input wire logic data_area_write_enable_o
);
    // 64 busy cycles plus slack for the registered start and end
    localparam int BUSY_MAX = 66;
    logic cmd_wr;
    logic region_on;
    logic known_cmd;
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    assign cmd_wr = sfr_wr_i && sfr_addr_i == 8'h86 && !cpu_stall_o;
    assign known_cmd = sfr_wdata_i == 8'h9a || sfr_wdata_i == 8'ha6;
    // the data flash block is 1K aligned, so the erase base decodes alike
    assign region_on = (flash_addr_o >= 16'hf000 && flash_addr_o <= 16'hf3ff) ?
        data_area_write_enable_o : code_area_write_enable_o;

    prog_start_a: assert property (cmd_wr && sfr_wdata_i == 8'h9a && region_on |=>
        flash_program_o && !flash_erase_o) else $error("program did not start");
    erase_start_a: assert property (cmd_wr && sfr_wdata_i == 8'ha6 && region_on |=>
        flash_erase_o && !flash_program_o) else $error("erase did not start");
    locked_refuse_a: assert property (cmd_wr && known_cmd && !region_on |=>
        !cpu_stall_o) else $error("command ran on protected region");
    bad_cmd_a: assert property (cmd_wr && !known_cmd |=> !cpu_stall_o)
        else $error("unknown command started an operation");
    stall_tie_a: assert property (cpu_stall_o == (flash_erase_o || flash_program_o))
        else $error("stall does not follow flash operation");
    busy_bound_a: assert property ($rose(cpu_stall_o) |-> ##[1:BUSY_MAX] !cpu_stall_o)
        else $error("flash operation exceeded its timeout");
    done_end_a: assert property (cpu_stall_o && flash_done_i |=> !cpu_stall_o)
        else $error("operation kept running after done");
    erase_block_a: assert property (flash_erase_o |-> flash_addr_o[9:0] == 10'h000)
        else $error("erase address not a block base");
    even_addr_a: assert property (flash_program_o |-> !flash_addr_o[0])
        else $error("program address is odd");
    sreset_pulse_a: assert property (soft_reset_o |=> !soft_reset_o)
        else $error("soft reset longer than one cycle");
    wdog_gate_a: assert property (watchdog_reset_o |-> watchdog_overflow_i)
        else $error("watchdog reset without overflow");
    boot_vec_a: assert property (boot_start_o == (config_word_i[14] ? 16'hf400 : 16'h0000))
        else $error("start address mismatch");
    cfg_pins_a: assert property (ext_read_allow_o == config_word_i[15] &&
        external_reset_pin_enable_o == config_word_i[11]) else $error("config pins mismatch");
    xbus_dec_a: assert property (!xdata_indirect_i && xdata_addr_i >= 16'h4000 |->
        xdata_xbus_sel_o && !xdata_ram_sel_o && !xdata_xreg_sel_o) else $error("bus decode");
    xreg_dec_a: assert property (xdata_addr_i >= 16'h2440 && xdata_addr_i <= 16'h298f |->
        xdata_xreg_sel_o && !xdata_xbus_sel_o) else $error("extended register decode");
endmodule
bind smc_sysctl smc_sysctl_checker chk_u (.*);
`default_nettype wire

// ==== bench/tb_smc_sysctl.sv ====
/*
 * Self-checking bench for the system control block: register access,
 * unlock window, flash commands, decode and configuration outputs.
 * Assumes the checker is bound separately; 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_smc_sysctl;
    // arbitrary identity value
    localparam [7:0] PART_ID = 8'h3c;
    logic ref_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic por_i = 1'b1;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [15:0] config_word_i = 16'heeff;
    logic watchdog_overflow_i = 1'b0;
    logic [15:0] xdata_addr_i = 16'h0000;
    logic xdata_indirect_i = 1'b0;
    logic flash_done_i = 1'b0;
    wire [7:0] sfr_rdata_o;
    wire [15:0] flash_addr_o, flash_wdata_o, boot_start_o;
    wire xdata_ram_sel_o, xdata_xreg_sel_o, xdata_xbus_sel_o, flash_erase_o, flash_program_o;
    wire cpu_stall_o, soft_reset_o, watchdog_reset_o, ext_read_allow_o, reset_hold_o;
    wire external_reset_pin_enable_o, port0_reset_pullup_enable_o;
    wire code_area_write_enable_o, data_area_write_enable_o;
    integer num_errors = 0;
    integer num_checks = 0;
    integer n;

    // short long-reset count keeps the run brief
    smc_sysctl #(.PART_ID(PART_ID), .LONG_RESET_CYC(20)) dut_u (.*);

    initial
    begin
        forever #12.5 ref_clk_i = ~ref_clk_i;
    end

    task summarize;
    begin
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    task chk(input [15:0] got, input [15:0] exp);
    begin
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask

    task wr(input [7:0] a, input [7:0] v);
    begin
        @(negedge ref_clk_i);
        sfr_addr_i = a;
        sfr_wdata_i = v;
        sfr_wr_i = 1'b1;
        @(negedge ref_clk_i);
        sfr_wr_i = 1'b0;
    end
    endtask

    task rdc(input [7:0] a, input [7:0] e);
    begin
        @(negedge ref_clk_i);
        sfr_addr_i = a;
        @(negedge ref_clk_i);
        chk(sfr_rdata_o, e);
    end
    endtask

    task unlock;
    begin
        wr(8'ha1, 8'h55);
        wr(8'ha1, 8'haa);
    end
    endtask

    task dec(input [15:0] a, input ind, input [2:0] e);
    begin
        @(negedge ref_clk_i);
        xdata_addr_i = a;
        xdata_indirect_i = ind;
        #1;
        chk({xdata_ram_sel_o, xdata_xreg_sel_o, xdata_xbus_sel_o}, e);
    end
    endtask

    task fop(input [7:0] cmd, input bsy, input integer dly, input [7:0] st, input [15:0] fa);
    begin
        wr(8'h86, cmd);
        chk({cpu_stall_o, flash_program_o, flash_erase_o},
            {bsy, bsy && cmd == 8'h9a, bsy && cmd == 8'ha6});
        if (bsy)
        begin
            chk(flash_addr_o, fa);
            for (n = 0; n < 80 && cpu_stall_o !== 1'b0; n++)
            begin
                flash_done_i = (n == dly);
                @(negedge ref_clk_i);
            end
            flash_done_i = 1'b0;
            if (cpu_stall_o !== 1'b0)
            begin
                num_errors++;
                summarize;
            end
        end
        rdc(8'h86, st);
    end
    endtask

    initial
    begin
        repeat (12) @(negedge ref_clk_i);
        chk(port0_reset_pullup_enable_o, 1'b1);
        srst_i = 1'b0;
        por_i = 1'b0;
        chk(reset_hold_o, 1'b1);
        for (n = 0; n < 60 && reset_hold_o !== 1'b0; n++)
            @(negedge ref_clk_i);
        chk(reset_hold_o, 1'b0);
        if (reset_hold_o !== 1'b0)
            summarize;
        chk(port0_reset_pullup_enable_o, 1'b0);
        chk(boot_start_o, 16'hf400);
        chk({ext_read_allow_o, external_reset_pin_enable_o}, 2'b11);
        config_word_i = 16'h02ff;
        #1;
        chk(boot_start_o, 16'h0000);
        chk({ext_read_allow_o, external_reset_pin_enable_o}, 2'b00);
        rdc(8'h86, 8'h80);
        rdc(8'hb1, 8'he0);
        rdc(8'ha1, PART_ID);
        wr(8'hb1, 8'h0f);
        rdc(8'hb1, 8'he0);
        wr(8'ha1, 8'haa);
        wr(8'ha1, 8'h55);
        wr(8'h84, 8'h00);
        wr(8'ha1, 8'haa);
        wr(8'hb1, 8'h0f);
        rdc(8'hb1, 8'he0);
        unlock;
        wr(8'ha1, 8'h00);
        wr(8'hb1, 8'h0f);
        rdc(8'hb1, 8'he0);
        unlock;
        repeat (22) @(negedge ref_clk_i);
        wr(8'hb1, 8'h0f);
        rdc(8'hb1, 8'he0);
        unlock;
        repeat (8) @(negedge ref_clk_i);
        wr(8'hb1, 8'h0f);
        rdc(8'hb1, 8'hef);
        chk({code_area_write_enable_o, data_area_write_enable_o}, 2'b11);
        wr(8'h84, 8'h13);
        wr(8'h85, 8'hf0);
        wr(8'h8e, 8'h34);
        wr(8'h8f, 8'h12);
        rdc(8'h84, 8'h12);
        fop(8'h9a, 1'b1, 3, 8'hc0, 16'hf012);
        chk(flash_wdata_o, 16'h1234);
        fop(8'h9a, 1'b1, 99, 8'hc1, 16'hf012);
        wr(8'h86, 8'h5a);
        chk(cpu_stall_o, 1'b0);
        rdc(8'h86, 8'h82);
        rdc(8'h84, 8'h12);
        rdc(8'h85, 8'hf0);
        rdc(8'h8e, 8'h34);
        rdc(8'h8f, 8'h12);
        wr(8'h84, 8'h34);
        wr(8'h85, 8'h12);
        fop(8'ha6, 1'b1, 5, 8'hc0, 16'h1000);
        watchdog_overflow_i = 1'b1;
        #1;
        chk(watchdog_reset_o, 1'b1);
        dec(16'h0100, 1'b1, 3'b010);
        dec(16'h0000, 1'b0, 3'b100);
        dec(16'h17ff, 1'b0, 3'b100);
        dec(16'h1800, 1'b0, 3'b000);
        dec(16'h2440, 1'b0, 3'b010);
        dec(16'h298f, 1'b0, 3'b010);
        dec(16'h2990, 1'b0, 3'b000);
        dec(16'h4000, 1'b0, 3'b001);
        dec(16'hffff, 1'b0, 3'b001);
        unlock;
        wr(8'hb1, 8'h00);
        chk(watchdog_reset_o, 1'b0);
        watchdog_overflow_i = 1'b0;
        dec(16'h0100, 1'b1, 3'b100);
        fop(8'ha6, 1'b0, 0, 8'h80, 16'h0000);
        wr(8'h84, 8'h12);
        wr(8'h85, 8'hf0);
        fop(8'h9a, 1'b0, 0, 8'h80, 16'h0000);
        unlock;
        wr(8'hb1, 8'h10);
        for (n = 0; n < 4 && soft_reset_o !== 1'b1; n++)
            @(negedge ref_clk_i);
        chk(soft_reset_o, 1'b1);
        srst_i = 1'b1;
        @(negedge ref_clk_i);
        srst_i = 1'b0;
        rdc(8'hb1, 8'hc0);
        summarize;
    end

    initial
    begin
        repeat (100000) @(posedge ref_clk_i);
        num_errors++;
        summarize;
    end
endmodule
`default_nettype wire
